// file: dpl_pkg.sv
// Package of constants for the digital loop core
package dpl_pkg;
    // Register word offsets (byte addresses)
    localparam logic [5:0] REG_LOOP_CONTROL   = 6'h00;
    localparam logic [5:0] REG_STATUS         = 6'h04;
    localparam logic [5:0] REG_TONE_WORD_LO   = 6'h08;
    localparam logic [5:0] REG_TONE_WORD_HI   = 6'h0c;
    localparam logic [5:0] REG_PHASE_OFFSET   = 6'h10;
    localparam logic [5:0] REG_OVERSAMPLE_EXP = 6'h14;
    localparam logic [5:0] REG_LOOP_GAIN      = 6'h18;
    localparam logic [5:0] REG_HOLD_WORD_LO   = 6'h1c;
    localparam logic [5:0] REG_HOLD_WORD_HI   = 6'h20;
    localparam logic [5:0] REG_IDENT          = 6'h24;

    // Loop control fields
    localparam int CTL_CLOSE_BIT     = 0;
    localparam int CTL_TONE_BIT      = 1;
    localparam int CTL_HOLD_MAN_BIT  = 2;
    localparam int CTL_HOLD_AUTO_BIT = 3;
    localparam int CTL_EST_EN_BIT    = 4;
    localparam int CTL_EST_SRC_BIT   = 5;

    localparam logic [31:0] CTL_RESET       = 32'h0000_0000;
    localparam logic [4:0]  OS_EXP_MIN      = 5'h05;
    localparam logic [4:0]  OS_EXP_MAX      = 5'h10;
    localparam logic [4:0]  OS_EXP_RESET    = 5'h05;
    localparam logic [3:0]  GAIN_RESET      = 4'h4;
    localparam logic [31:0] IDENT_VALUE     = 32'h0000_5a5a;  // Arbitrary value

    localparam int ACC_W   = 48;
    localparam int PHASE_W = 16;
    localparam int ERR_W   = 24;

    typedef enum logic [1:0] {
        DPL_MODE_CLOSED = 2'b00,
        DPL_MODE_TONE   = 2'b01,
        DPL_MODE_HOLD   = 2'b10,
        DPL_MODE_EST    = 2'b11
    } dpl_mode_t;
endpackage

// file: dpl_core.sv
// Digital loop core: detector select, loop filter, interpolator, synthesizer
//
// The Avalon-MM slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module dpl_core
    import dpl_pkg::*;
#(
    parameter int AVG_SHIFT = 4
) (
    input  wire logic               clk_sys_in,
    input  wire logic               reset_in,
    input  wire logic [5:0]         avs_address_in,
    input  wire logic               avs_read_in,
    input  wire logic               avs_write_in,
    input  wire logic [31:0]        avs_writedata_in,
    input  wire logic [3:0]         avs_byteenable_in,
    output logic [31:0]             avs_readdata_out,
    output logic                    avs_waitrequest_out,
    input  wire logic               ref_div_edge_in,
    input  wire logic [ERR_W-1:0]   fine_err_in,
    input  wire logic               fine_ovf_in,
    input  wire logic               fine_unf_in,
    input  wire logic [ERR_W-1:0]   coarse_err_in,
    input  wire logic               ref_lost_in,
    input  wire logic               est_done_in,
    input  wire logic [ACC_W-1:0]   est_step_in,
    input  wire logic [PHASE_W-1:0] est_phase_in,
    output logic [PHASE_W-1:0]      synth_phase_out,
    output logic                    loop_active_out
);
    // Register storage
    logic [31:0]        ctl_q;
    logic [ACC_W-1:0]   tone_word_q;
    logic [PHASE_W-1:0] phase_off_q;
    logic [4:0]         os_exp_q;
    logic [3:0]         gain_q;

    // Pin synchronisers
    logic               ref_m_q, ref_s_q, ref_p_q;
    logic               lost_m_q, lost_s_q;
    logic               done_m_q, done_s_q;

    // Datapath state
    logic [ERR_W-1:0]   err_q;
    logic               err_new_q;
    logic [ACC_W-1:0]   integ_q, prop_q, filt_q;
    logic [16:0]        os_cnt_q;
    logic               os_tick;
    logic [ACC_W-1:0]   comb1_q, comb1_dly_q, comb2_dly_q, comb2_q;
    logic [ACC_W+33:0]  int1_q, int2_q;
    logic [ACC_W-1:0]   interp_out;
    logic [ACC_W-1:0]   avg_q;
    logic               was_closed_q;
    logic               est_loaded_q;
    logic [ACC_W-1:0]   acc_q;
    logic [ACC_W-1:0]   step_word;
    dpl_mode_t          mode;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                                input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Bus: every access answers in the cycle after it is presented
    logic acc_pend_q;
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            acc_pend_q <= 1'b0;
        end else begin
            acc_pend_q <= (avs_read_in | avs_write_in) & ~acc_pend_q;
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            avs_waitrequest_out <= 1'b1;
        end else begin
            avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & ~acc_pend_q);
        end
    end

    wire bus_wr = avs_write_in & acc_pend_q;

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            ctl_q       <= CTL_RESET;
            tone_word_q <= '0;
            phase_off_q <= '0;
            os_exp_q    <= OS_EXP_RESET;
            gain_q      <= GAIN_RESET;
        end else if (bus_wr) begin
            unique case (avs_address_in)
                REG_LOOP_CONTROL: ctl_q <= merge_bytes(ctl_q, avs_writedata_in, avs_byteenable_in);
                REG_TONE_WORD_LO: tone_word_q[31:0] <= merge_bytes(tone_word_q[31:0], avs_writedata_in,
                                                                   avs_byteenable_in);
                REG_TONE_WORD_HI: tone_word_q[47:32] <= 16'(merge_bytes({16'h0000, tone_word_q[47:32]},
                                                                        avs_writedata_in, avs_byteenable_in));
                REG_PHASE_OFFSET: phase_off_q <= 16'(merge_bytes({16'h0000, phase_off_q}, avs_writedata_in,
                                                                 avs_byteenable_in));
                REG_OVERSAMPLE_EXP: begin
                    // Clamp to the legal exponent range
                    if (avs_writedata_in[4:0] < OS_EXP_MIN) begin
                        os_exp_q <= OS_EXP_MIN;
                    end else if (avs_writedata_in[4:0] > OS_EXP_MAX) begin
                        os_exp_q <= OS_EXP_MAX;
                    end else begin
                        os_exp_q <= avs_writedata_in[4:0];
                    end
                end
                REG_LOOP_GAIN: gain_q <= avs_writedata_in[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (avs_read_in & ~acc_pend_q) begin
            unique case (avs_address_in)
                REG_LOOP_CONTROL:   avs_readdata_out <= ctl_q;
                REG_STATUS:         avs_readdata_out <= {26'h0, lost_s_q, est_loaded_q, was_closed_q,
                                                         mode == DPL_MODE_HOLD, mode};
                REG_TONE_WORD_LO:   avs_readdata_out <= tone_word_q[31:0];
                REG_TONE_WORD_HI:   avs_readdata_out <= {16'h0000, tone_word_q[47:32]};
                REG_PHASE_OFFSET:   avs_readdata_out <= {16'h0000, phase_off_q};
                REG_OVERSAMPLE_EXP: avs_readdata_out <= {27'h0, os_exp_q};
                REG_LOOP_GAIN:      avs_readdata_out <= {28'h0, gain_q};
                REG_HOLD_WORD_LO:   avs_readdata_out <= avg_q[31:0];
                REG_HOLD_WORD_HI:   avs_readdata_out <= {16'h0000, avg_q[47:32]};
                REG_IDENT:          avs_readdata_out <= IDENT_VALUE;
                default:            avs_readdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // Two-stage synchronisers for pin inputs
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            {ref_m_q, ref_s_q, ref_p_q}        <= 3'b000;
            {lost_m_q, lost_s_q, done_m_q, done_s_q} <= 4'h0;
        end else begin
            ref_m_q  <= ref_div_edge_in;
            ref_s_q  <= ref_m_q;
            ref_p_q  <= ref_s_q;
            lost_m_q <= ref_lost_in;
            lost_s_q <= lost_m_q;
            done_m_q <= est_done_in;
            done_s_q <= done_m_q;
        end
    end

    // Mode selection; single tone by the tone bit, or as the fallback while open and never closed
    always_comb begin
        if (ctl_q[CTL_TONE_BIT]) begin
            mode = DPL_MODE_TONE;
        end else if (ctl_q[CTL_EST_EN_BIT] && !est_loaded_q) begin
            mode = DPL_MODE_EST;
        end else if (was_closed_q && (ctl_q[CTL_HOLD_MAN_BIT] ||
                     (ctl_q[CTL_HOLD_AUTO_BIT] && lost_s_q) || !ctl_q[CTL_CLOSE_BIT])) begin
            mode = DPL_MODE_HOLD;
        end else if (ctl_q[CTL_CLOSE_BIT]) begin
            mode = DPL_MODE_CLOSED;
        end else begin
            mode = DPL_MODE_TONE;
        end
    end

    // Estimator load: loop idle until the estimate lands
    always_ff @(posedge clk_sys_in) begin
        if (reset_in || !ctl_q[CTL_EST_EN_BIT]) begin
            est_loaded_q <= 1'b0;
        end else if (done_s_q) begin
            est_loaded_q <= 1'b1;
        end
    end

    // Detector select, one sample per divided reference edge; coarse path taken when the fine path overflows or underflows
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            err_q     <= '0;
            err_new_q <= 1'b0;
        end else begin
            // Sample waits for the slow tick; a new edge wins over the clear
            err_new_q <= (ref_s_q & ~ref_p_q) | (err_new_q & ~os_tick);
            if (ref_s_q & ~ref_p_q) begin
                err_q <= (fine_ovf_in | fine_unf_in) ? coarse_err_in
                                                     : fine_err_in;
            end
        end
    end

    // Oversample divider: tick every 2^exp sample clocks
    assign os_tick = (os_cnt_q == 17'(({16'h0000, 1'b1} << os_exp_q) - 1));
    always_ff @(posedge clk_sys_in) begin
        if (reset_in || os_tick) begin
            os_cnt_q <= '0;
        end else begin
            os_cnt_q <= os_cnt_q + 17'h00001;
        end
    end

    // Loop filter: integral plus proportional, updated at the slow rate
    logic [ACC_W-1:0] err_ext;
    assign err_ext = ACC_W'(signed'(err_q));
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            integ_q <= '0;
            prop_q  <= '0;
            filt_q  <= '0;
        end else if (mode != DPL_MODE_CLOSED) begin
            integ_q <= est_loaded_q ? est_step_in : avg_q;
            prop_q  <= '0;
            filt_q  <= est_loaded_q ? est_step_in : avg_q;
        end else if (os_tick) begin
            if (err_new_q) begin
                integ_q <= integ_q + (err_ext << gain_q);
                prop_q  <= err_ext << (5'(gain_q) + 5'h04);
            end
            filt_q <= integ_q + prop_q;
        end
    end

    // Second-order comb at slow rate, integrators at full rate
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            comb1_dly_q <= '0;
            comb1_q     <= '0;
            comb2_dly_q <= '0;
            comb2_q     <= '0;
        end else if (os_tick) begin
            comb1_dly_q <= filt_q;
            comb1_q     <= filt_q - comb1_dly_q;
            comb2_dly_q <= comb1_q;
            comb2_q     <= comb1_q - comb2_dly_q;
        end
    end

    logic [ACC_W+33:0] comb_ext;
    assign comb_ext = (ACC_W+34)'(signed'(comb2_q));
    always_ff @(posedge clk_sys_in) begin
        if (reset_in || mode != DPL_MODE_CLOSED) begin
            int1_q <= '0;
            int2_q <= '0;
        end else begin
            int1_q <= int1_q + (os_tick ? comb_ext : '0);
            int2_q <= int2_q + int1_q;
        end
    end
    // Divide by P squared, leaving a DC gain of 1/P
    assign interp_out = ACC_W'(int2_q >> {os_exp_q, 1'b0});

    // Holdover history: running average while locked closed
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            avg_q        <= '0;
            was_closed_q <= 1'b0;
        end else if (mode == DPL_MODE_CLOSED && os_tick) begin
            avg_q        <= avg_q + ACC_W'((signed'(interp_out) - signed'(avg_q)) >>> AVG_SHIFT);
            was_closed_q <= 1'b1;
        end
    end

    // Step word source per mode
    always_comb begin
        unique case (mode)
            DPL_MODE_CLOSED: step_word = interp_out;
            DPL_MODE_HOLD:   step_word = avg_q;
            DPL_MODE_EST:    step_word = '0;
            DPL_MODE_TONE:   step_word = ctl_q[CTL_EST_SRC_BIT] ? est_step_in : tone_word_q;
        endcase
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            acc_q <= '0;
        end else begin
            acc_q <= acc_q + step_word;
        end
    end

    // Phase output with offset only in open loop
    logic [PHASE_W-1:0] offs;
    assign offs = (mode == DPL_MODE_CLOSED) ? '0
                  : ((mode == DPL_MODE_TONE && ctl_q[CTL_EST_SRC_BIT]) ? est_phase_in : phase_off_q);
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            synth_phase_out <= '0;
            loop_active_out <= 1'b0;
        end else begin
            synth_phase_out <= acc_q[ACC_W-1 -: PHASE_W] + offs;
            loop_active_out <= (mode == DPL_MODE_CLOSED);
        end
    end
endmodule

`default_nettype wire

// file: dpl_core_assertions.sv
// Port checker for the digital loop core
`timescale 1ns/10ps
`default_nettype none
module dpl_core_chk
    import dpl_pkg::*;
#(
    parameter int AVG_SHIFT = 4
) (
    input wire logic               clk_sys_in,
    input wire logic               reset_in,
    input wire logic [5:0]         avs_address_in,
    input wire logic               avs_read_in,
    input wire logic               avs_write_in,
    input wire logic [31:0]        avs_writedata_in,
    input wire logic [31:0]        avs_readdata_out,
    input wire logic               avs_waitrequest_out,
    input wire logic [PHASE_W-1:0] synth_phase_out,
    input wire logic               loop_active_out
);
    logic [5:0]  ctl_q;
    logic [4:0]  exp_q;
    logic [47:0] tone_q;
    wire         done = !avs_waitrequest_out;
    wire  [4:0]  wexp = avs_writedata_in[4:0];

    // Shadow of the written control, tone word and exponent registers
    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            ctl_q <= 6'h00;
            exp_q <= OS_EXP_RESET;
            tone_q <= 48'h0;
        end else if (avs_write_in && done) begin
            if (avs_address_in == REG_LOOP_CONTROL) ctl_q <= avs_writedata_in[5:0];
            if (avs_address_in == REG_TONE_WORD_LO) tone_q[31:0] <= avs_writedata_in;
            if (avs_address_in == REG_TONE_WORD_HI) tone_q[47:32] <= avs_writedata_in[15:0];
            if (avs_address_in == REG_OVERSAMPLE_EXP)
                exp_q <= (wexp < OS_EXP_MIN) ? OS_EXP_MIN : (wexp > OS_EXP_MAX) ? OS_EXP_MAX : wexp;
        end
    end

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (reset_in);

    wait_one_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> done)
        else $error("late bus answer");
    wait_short_a: assert property (done |=> avs_waitrequest_out)
        else $error("wait low too long");
    wait_idle_a: assert property (!avs_read_in && !avs_write_in |=> avs_waitrequest_out)
        else $error("answer without request");
    reset_out_a: assert property ($fell(reset_in) |-> synth_phase_out == 16'h0 && !loop_active_out)
        else $error("outputs not cleared by reset");
    ident_read_a: assert property (avs_read_in && done && avs_address_in == REG_IDENT |->
        avs_readdata_out == IDENT_VALUE) else $error("bad ident");
    unmapped_read_a: assert property (avs_read_in && done && avs_address_in > REG_IDENT |->
        avs_readdata_out == 32'h0) else $error("unmapped read not zero");
    ctl_back_a: assert property (avs_read_in && done && avs_address_in == REG_LOOP_CONTROL |->
        avs_readdata_out[5:0] == ctl_q) else $error("control readback");
    exp_clamp_a: assert property (avs_read_in && done && avs_address_in == REG_OVERSAMPLE_EXP |->
        avs_readdata_out[4:0] == exp_q) else $error("exponent readback");
    open_idle_a: assert property (!ctl_q[CTL_CLOSE_BIT] [*3] |-> !loop_active_out)
        else $error("loop active while open");
    tone_step_a: assert property ((ctl_q == 6'h02 && tone_q[31:0] == 32'h0 && !avs_write_in) [*6] |->
        synth_phase_out - $past(synth_phase_out) == tone_q[47:32]) else $error("tone step wrong");

    cover property (loop_active_out);
    cover property (avs_write_in && done && avs_address_in == REG_OVERSAMPLE_EXP);
    cover property (ctl_q[CTL_HOLD_MAN_BIT] && !loop_active_out);
endmodule

bind dpl_core dpl_core_chk #(.AVG_SHIFT(AVG_SHIFT)) u_chk (.clk_sys_in, .reset_in, .avs_address_in,
    .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out,
    .synth_phase_out, .loop_active_out);
`default_nettype wire

// file: dpl_ref_src.sv
// Divided reference and detector model facing the loop core
`timescale 1ns/10ps
`default_nettype none
module dpl_ref_src
    import dpl_pkg::*;
(
    input  wire logic             clk_in,
    input  wire logic             run_in,
    input  wire logic             ovf_in,
    input  wire logic             unf_in,
    input  wire logic [ERR_W-1:0] fine_in,
    input  wire logic [ERR_W-1:0] coarse_in,
    output logic                  edge_out,
    output logic [ERR_W-1:0]      fine_out,
    output logic [ERR_W-1:0]      coarse_out,
    output logic                  ovf_out,
    output logic                  unf_out
);
    logic [4:0]         cnt_q = 5'h00;
    logic [2*ERR_W+2:0] out_q = '0;

    // Reference period of 20 clocks, high for 10
    always_ff @(posedge clk_in) begin
        cnt_q <= (cnt_q == 5'h13) ? 5'h00 : cnt_q + 5'h01;
        if (!run_in) begin
            out_q <= {1'b0, ~out_q[2*ERR_W+1:2], 2'b00};
        end else if (cnt_q == 5'h00) begin
            out_q <= {1'b1, fine_in, coarse_in, ovf_in, unf_in};
        end else begin
            out_q[2*ERR_W+2] <= cnt_q < 5'h0a;
        end
    end
    assign {edge_out, fine_out, coarse_out, ovf_out, unf_out} = out_q;
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the digital loop core
`timescale 1ns/10ps
`default_nettype none
module testbench
    import dpl_pkg::*;
;
    logic               clk_sys_in = 1'b0;
    logic               reset_in = 1'b1;
    logic [5:0]         avs_address_in = 6'h00;
    logic               avs_read_in = 1'b0;
    logic               avs_write_in = 1'b0;
    logic [31:0]        avs_writedata_in = 32'h0;
    logic [3:0]         avs_byteenable_in = 4'hf;
    logic [31:0]        avs_readdata_out;
    logic               avs_waitrequest_out;
    logic               ref_div_edge_in;
    logic [ERR_W-1:0]   fine_err_in;
    logic               fine_ovf_in;
    logic               fine_unf_in;
    logic [ERR_W-1:0]   coarse_err_in;
    logic               ref_lost_in = 1'b0;
    logic               est_done_in = 1'b0;
    logic [ACC_W-1:0]   est_step_in = 48'h0;
    logic [PHASE_W-1:0] est_phase_in = 16'h0;
    logic [PHASE_W-1:0] synth_phase_out;
    logic               loop_active_out;
    logic               run = 1'b0;
    logic [1:0]         flags = 2'b00;
    int                 failures = 0;
    int                 checks = 0;

    dpl_core u_dut (.clk_sys_in, .reset_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
        .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .ref_div_edge_in, .fine_err_in,
        .fine_ovf_in, .fine_unf_in, .coarse_err_in, .ref_lost_in, .est_done_in, .est_step_in, .est_phase_in,
        .synth_phase_out, .loop_active_out);
    dpl_ref_src u_src (.clk_in(clk_sys_in), .run_in(run), .ovf_in(flags[1]), .unf_in(flags[0]),
        .fine_in(24'h7fff00), .coarse_in(24'h800100), .edge_out(ref_div_edge_in), .fine_out(fine_err_in),
        .coarse_out(coarse_err_in), .ovf_out(fine_ovf_in), .unf_out(fine_unf_in));

    initial forever #5 clk_sys_in = ~clk_sys_in;

    task automatic print_verdict();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_write_in <= w;
        avs_read_in <= !w;
        @(posedge clk_sys_in);
        while (avs_waitrequest_out !== 1'b0) begin
            @(posedge clk_sys_in);
        end
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdchk(input string what, input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(what, q & m, e);
    endtask

    // Phase advance over a span, after settling
    task automatic delta(input int gap, output logic [15:0] d);
        logic [15:0] p;
        repeat (8) @(posedge clk_sys_in);
        p = synth_phase_out;
        repeat (gap) @(posedge clk_sys_in);
        d = synth_phase_out - p;
    endtask

    task automatic do_reset();
        run <= 1'b0;
        reset_in <= 1'b1;
        repeat (5) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        @(posedge clk_sys_in);
    endtask

    task automatic t_regs();
        logic [4:0] wv [4] = '{5'h04, 5'h05, 5'h10, 5'h11};
        logic [4:0] ev [4] = '{5'h05, 5'h05, 5'h10, 5'h10};
        do_reset();
        rdchk("control", REG_LOOP_CONTROL, 32'hffffffff, CTL_RESET);
        rdchk("exponent", REG_OVERSAMPLE_EXP, 32'h1f, 32'(OS_EXP_RESET));
        rdchk("ident", REG_IDENT, 32'hffffffff, IDENT_VALUE);
        rdchk("unmapped", 6'h3c, 32'hffffffff, 32'h0);
        for (int i = 0; i < 4; i++) begin
            wr(REG_OVERSAMPLE_EXP, 32'(wv[i]));
            rdchk("exponent clamp", REG_OVERSAMPLE_EXP, 32'h1f, 32'(ev[i]));
        end
        $display("test registers done");
    endtask

    task automatic t_tone();
        logic [15:0] hv [3] = '{16'h0001, 16'hffff, 16'h8000};
        logic [15:0] d;
        do_reset();
        wr(REG_PHASE_OFFSET, 32'h1234);
        wr(REG_LOOP_CONTROL, 32'h02);
        run <= 1'b1;
        delta(1, d);
        chk("offset", 32'(synth_phase_out), 32'h1234);
        wr(REG_PHASE_OFFSET, 32'h1334);
        delta(1, d);
        chk("offset moved", 32'(synth_phase_out), 32'h1334);
        for (int i = 0; i < 3; i++) begin
            wr(REG_TONE_WORD_HI, 32'(hv[i]));
            delta(1, d);
            chk("tone step", 32'(d), 32'(hv[i]));
        end
        est_step_in <= 48'h0003_0000_0000;
        wr(REG_LOOP_CONTROL, 32'h22);
        delta(1, d);
        chk("estimator step", 32'(d), 32'h3);
        chk("tone idle", 32'(loop_active_out), 32'h0);
        $display("test tone done");
    endtask

    task automatic t_closed();
        logic [15:0] d;
        do_reset();
        wr(REG_LOOP_CONTROL, 32'h01);
        delta(4, d);
        chk("active", 32'(loop_active_out), 32'h1);
        chk("quiet step", 32'(d), 32'h0);
        wr(REG_PHASE_OFFSET, 32'h4000);
        delta(1, d);
        chk("closed offset", 32'(synth_phase_out), 32'h0);
        wr(REG_LOOP_CONTROL, 32'h11);
        rdchk("estimating", REG_STATUS, 32'h13, 32'h03);
        est_done_in <= 1'b1;
        repeat (4) @(posedge clk_sys_in);
        rdchk("estimate loaded", REG_STATUS, 32'h13, 32'h10);
        est_done_in <= 1'b0;
        $display("test closed done");
    endtask

    task automatic closed_run(input logic [1:0] f);
        do_reset();
        flags <= f;
        run <= 1'b1;
        wr(REG_LOOP_CONTROL, 32'h01);
        repeat (600) @(posedge clk_sys_in);
    endtask

    task automatic t_detect();
        logic [1:0] fv [3] = '{2'b00, 2'b10, 2'b01};
        logic [15:0] d;
        for (int i = 0; i < 3; i++) begin
            closed_run(fv[i]);
            delta(320, d);
            chk("moving", 32'(d == 16'h0), 32'h0);
            chk("error sign", 32'(d[15]), 32'(fv[i] != 2'b00));
        end
        $display("test detector done");
    endtask

    task automatic t_hold();
        logic [15:0] d;
        do_reset();
        wr(REG_LOOP_CONTROL, 32'h04);
        rdchk("never closed", REG_STATUS, 32'h08, 32'h0);
        closed_run(2'b00);
        wr(REG_LOOP_CONTROL, 32'h05);
        delta(320, d);
        rdchk("manual hold", REG_STATUS, 32'h0f, 32'h0e);
        chk("hold rising", 32'(d[15] || d == 16'h0), 32'h0);
        chk("hold idle", 32'(loop_active_out), 32'h0);
        wr(REG_LOOP_CONTROL, 32'h09);
        rdchk("auto closed", REG_STATUS, 32'h27, 32'h0);
        ref_lost_in <= 1'b1;
        repeat (8) @(posedge clk_sys_in);
        rdchk("auto hold", REG_STATUS, 32'h27, 32'h26);
        ref_lost_in <= 1'b0;
        repeat (8) @(posedge clk_sys_in);
        rdchk("auto exit", REG_STATUS, 32'h27, 32'h0);
        $display("test holdover done");
    endtask

    initial begin
        t_regs();
        t_tone();
        t_closed();
        t_detect();
        t_hold();
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge clk_sys_in);
        failures++;
        print_verdict();
    end
endmodule
`default_nettype wire
